// ==== port_protect_consts.svh ====
`ifndef PORT_PROTECT_CONSTS_SVH
`define PORT_PROTECT_CONSTS_SVH

// ****************************************
// Register offsets
// ****************************************
`define PP_REG_CTRL          8'h00
`define PP_REG_ACK           8'h01
`define PP_REG_FLAGS         8'h02

// ****************************************
// Control word fields
// ****************************************
`define PP_BIT_AUX_DIS       7
`define PP_BIT_BUS_DIS       6
`define PP_BIT_MODE_HI       5
`define PP_BIT_MODE_LO       4
`define PP_BIT_SINK_GATE     3
`define PP_BIT_SOURCE_GATE   2
`define PP_BIT_SW_HI         1
`define PP_BIT_SW_LO         0
`define PP_CTRL_RST          8'h00

// ****************************************
// Mode and switch encodings
// ****************************************
`define PP_MODE_HIB          2'h0
`define PP_MODE_LOWP         2'h2
`define PP_MODE_NORM         2'h1
`define PP_SW_CONN1          2'h1
`define PP_SW_CONN2          2'h2

// ****************************************
// Overcurrent recovery
// ****************************************
`define PP_RECOV_MASK        8'hcf
`define PP_RECOV_PAT         8'h08
`define PP_ACK_OCP_KEEP      8'h30
`define PP_CLK_PERIOD_NS     40
`define PP_OCP_HOLD_NS       40000
`define PP_OCP_HOLD_CYC      10'((`PP_OCP_HOLD_NS) / (`PP_CLK_PERIOD_NS))

// ****************************************
// Bus address
// ****************************************
`define PP_ADDR_BASE         6'h1a
`define PP_VARIANT           1'h0

`endif

// ==== port_protect_pkg.sv ====
package port_protect_pkg;

	typedef enum logic [3:0] {
		MODE_OFF  = 4'h1,
		MODE_HIB  = 4'h2,
		MODE_LOWP = 4'h4,
		MODE_NORM = 4'h8
	} mode_t;

	typedef enum logic [6:0] {
		ST_IDLE   = 7'h01,
		ST_ADDR   = 7'h02,
		ST_ACK    = 7'h04,
		ST_RX     = 7'h08,
		ST_TX     = 7'h10,
		ST_TXACK  = 7'h20,
		ST_TXNEXT = 7'h40
	} bus_st_t;

endpackage

// ==== pin_sync.sv ====
module pin_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             mclk_in,  // system clock
	input  wire logic             rst_n_in, // sync reset, active low
	input  wire logic [WIDTH-1:0] d_in,     // asynchronous pins
	output logic      [WIDTH-1:0] q_out     // synchronised copy
);

	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] meta_d;
	logic [WIDTH-1:0] sync_d;

	always_comb begin
		meta_d = d_in;
		sync_d = meta_q;
		if (!rst_n_in) begin
			meta_d = '0;
			sync_d = '0;
		end
	end

	always_ff @(posedge mclk_in) begin
		meta_q <= meta_d;
		q_out  <= sync_d;
	end

endmodule

// ==== port_protect_mode_ctrl.sv ====
`include "port_protect_consts.svh"

// Notes on behaviour
// R1 - Hibernate, low power and normal mode are chosen only by writing the control word.
// R2 - With enable low the block is off, the bus is silent and every register sits at reset.
// R3 - Once enabled the block starts in hibernate with the bus live and CC switches off.
// R4 - Outside normal mode the fault flag pin shows VBUS presence instead of faults.
// R5 - Low power makes the CC switches high ohmic and turns dead-battery termination off.
// R6 - Low power protects the CC lines by the passive clamp, normal mode by the active switch.
// R7 - The bus address is 0110 10x with x taken from the address-select pin.
// R8 - When off the sink gate stays on, and the source gate is on only in normal mode.
// R9 - Register 1 echoes the settings, register 2 holds active-high fault flags.
// R10 - In normal mode the flag pin is pulled low on any overvoltage, overcurrent or overtemp.
// R11 - In normal mode a VBUS overcurrent clears the acknowledge state bits and sets its flag bit.
// R12 - Mode bits 00 hibernate, 10 low power, 01 normal, 11 unused.
// R13 - Discharge and source bits act when 1, sink bit opens when 1, one VCONN switch at most.
module port_protect_mode_ctrl (
	input  wire logic mclk_in,             // 25 MHz clock
	input  wire logic rst_n_in,            // sync reset, active low
	input  wire logic enable_in,           // enable pin
	input  wire logic addr_sel_in,         // address-select pin
	input  wire logic scl_in,              // bus clock pin
	input  wire logic sda_in,              // bus data pin level
	input  wire logic vbus_present_in,     // VBUS above lockout
	input  wire logic cc_overvolt_in,      // CC overvoltage detector
	input  wire logic overtemp_in,         // overtemperature detector
	input  wire logic bus_overvolt_in,     // VBUS overvoltage detector
	input  wire logic bus_overcurrent_in,  // VBUS overcurrent detector
	input  wire logic aux_overcurrent_in,  // VCONN overcurrent detector
	output logic      sda_out,             // bus data drive level
	output logic      sda_oe_out,          // bus data pull low
	output logic      fault_flag_out,      // flag pin drive level
	output logic      fault_flag_oe_out,   // flag pin pull low
	output logic      cc_switch_on_out,    // CC switches fully on
	output logic      cc_high_ohmic_out,   // CC switches high ohmic
	output logic      cc_clamp_out,        // passive CC clamp in use
	output logic      dead_batt_term_out,  // dead-battery termination
	output logic      sink_gate_on_out,    // sink path gate driver
	output logic      source_gate_on_out,  // source path gate driver
	output logic      bus_discharge_out,   // VBUS discharge path
	output logic      aux_discharge_out,   // VCONN discharge path
	output logic      conn_switch1_out,    // VCONN switch 1 closed
	output logic      conn_switch2_out,    // VCONN switch 2 closed
	output logic      current_sense_out,   // current sense amp on
	output logic      i2c_active_out       // bus interface live
);

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [9:0] pins_s;
	logic       en_s;
	logic       asel_s;
	logic       scl_s;
	logic       sda_s;
	logic       vbus_s;
	logic       ccov_s;
	logic       otp_s;
	logic       bov_s;
	logic       boc_s;
	logic       aoc_s;

	pin_sync #(
		.WIDTH (10)
	) u_sync (
		.mclk_in  (mclk_in),
		.rst_n_in (rst_n_in),
		.d_in     ({enable_in, addr_sel_in, scl_in, sda_in, vbus_present_in,
			cc_overvolt_in, overtemp_in, bus_overvolt_in, bus_overcurrent_in,
			aux_overcurrent_in}),
		.q_out    (pins_s)
	);

	assign {en_s, asel_s, scl_s, sda_s, vbus_s, ccov_s, otp_s, bov_s, boc_s, aoc_s} = pins_s;

	logic run;
	assign run = rst_n_in & en_s; // see R2

	// ****************************************
	// Bus slave and control state
	// ****************************************
	port_protect_pkg::bus_st_t st_q, st_d;
	port_protect_pkg::mode_t   mode_q, mode_d;
	logic [7:0] sh_q, sh_d;
	logic [3:0] cnt_q, cnt_d;
	logic [7:0] ptr_q, ptr_d;
	logic       rd_q, rd_d;
	logic       first_q, first_d;
	logic       oe_q, oe_d;
	logic       scl_p_q, sda_p_q;
	logic [7:0] ctrl_q, ctrl_d;
	logic       lock_q, lock_d;
	logic [9:0] hold_q, hold_d;
	logic       ocp_p_q;
	logic [7:0] ack_q, ack_d;
	logic [7:0] flags_q, flags_d;
	logic [7:0] rbyte;
	logic       scl_rise, scl_fall, start, stop, ocp_rise, hold_done;

	assign scl_rise  = scl_s & ~scl_p_q;
	assign scl_fall  = ~scl_s & scl_p_q;
	assign start     = scl_s & scl_p_q & sda_p_q & ~sda_s;
	assign stop      = scl_s & scl_p_q & ~sda_p_q & sda_s;
	assign ocp_rise  = boc_s & ~ocp_p_q;
	assign hold_done = (hold_q == `PP_OCP_HOLD_CYC);

	// Control word is write-only and reads back as zero
	function automatic logic [7:0] read_reg(input logic [7:0] ptr, input logic [7:0] ack,
		input logic [7:0] flags);
		case (ptr)
			`PP_REG_ACK:   read_reg = ack;
			`PP_REG_FLAGS: read_reg = flags;
			default:       read_reg = 8'h00;
		endcase
	endfunction

	assign rbyte = read_reg(ptr_q, ack_q, flags_q); // see R9

	always_comb begin
		st_d    = st_q;
		sh_d    = sh_q;
		cnt_d   = cnt_q;
		ptr_d   = ptr_q;
		rd_d    = rd_q;
		first_d = first_q;
		oe_d    = oe_q;
		ctrl_d  = ctrl_q;
		lock_d  = lock_q;
		hold_d  = hold_q;
		// Recovery only accepted once the hold time has run out
		if (lock_q && !hold_done) begin
			hold_d = hold_q + 10'h001;
		end
		if (ocp_rise && mode_q == port_protect_pkg::MODE_NORM && !lock_q) begin
			lock_d = 1'b1; // see R11
			hold_d = 10'h000;
		end
		if (start) begin
			st_d  = port_protect_pkg::ST_ADDR;
			cnt_d = 4'h0;
			oe_d  = 1'b0;
		end else if (stop) begin
			st_d = port_protect_pkg::ST_IDLE;
			oe_d = 1'b0;
		end else begin
			case (st_q)
				port_protect_pkg::ST_IDLE: begin
					oe_d = 1'b0;
				end
				port_protect_pkg::ST_ADDR: begin
					if (scl_rise) begin
						sh_d  = {sh_q[6:0], sda_s};
						cnt_d = cnt_q + 4'h1;
					end else if (scl_fall && cnt_q == 4'h8) begin
						if (sh_q[7:1] == {`PP_ADDR_BASE, asel_s}) begin // see R7
							st_d    = port_protect_pkg::ST_ACK;
							oe_d    = 1'b1;
							rd_d    = sh_q[0];
							first_d = ~sh_q[0];
						end else begin
							st_d = port_protect_pkg::ST_IDLE;
						end
					end
				end
				port_protect_pkg::ST_ACK: begin
					if (scl_fall) begin
						cnt_d = 4'h0;
						sh_d  = rbyte;
						oe_d  = rd_q & ~rbyte[7];
						st_d  = rd_q ? port_protect_pkg::ST_TX : port_protect_pkg::ST_RX;
					end
				end
				port_protect_pkg::ST_RX: begin
					if (scl_rise) begin
						sh_d  = {sh_q[6:0], sda_s};
						cnt_d = cnt_q + 4'h1;
					end else if (scl_fall && cnt_q == 4'h8) begin
						st_d = port_protect_pkg::ST_ACK;
						oe_d = 1'b1;
						if (first_q) begin
							ptr_d   = sh_q;
							first_d = 1'b0;
						end else begin
							ptr_d = ptr_q + 8'h01;
							if (ptr_q == `PP_REG_CTRL) begin
								if (!lock_q) begin
									ctrl_d = sh_q; // see R1
								end else if (hold_done &&
									(sh_q & `PP_RECOV_MASK) == `PP_RECOV_PAT) begin
									ctrl_d = sh_q;
									lock_d = 1'b0;
								end
							end
						end
					end
				end
				port_protect_pkg::ST_TX: begin
					if (scl_fall) begin
						if (cnt_q == 4'h7) begin
							st_d  = port_protect_pkg::ST_TXACK;
							oe_d  = 1'b0;
							cnt_d = 4'h0;
						end else begin
							sh_d  = {sh_q[6:0], 1'b0};
							oe_d  = ~sh_q[6];
							cnt_d = cnt_q + 4'h1;
						end
					end
				end
				port_protect_pkg::ST_TXACK: begin
					if (scl_rise) begin
						if (sda_s) begin
							st_d = port_protect_pkg::ST_IDLE;
						end else begin
							st_d  = port_protect_pkg::ST_TXNEXT;
							ptr_d = ptr_q + 8'h01;
						end
					end
				end
				port_protect_pkg::ST_TXNEXT: begin
					if (scl_fall) begin
						sh_d  = rbyte;
						oe_d  = ~rbyte[7];
						cnt_d = 4'h0;
						st_d  = port_protect_pkg::ST_TX;
					end
				end
				default: begin
					st_d = port_protect_pkg::ST_IDLE;
					oe_d = 1'b0;
				end
			endcase
		end
		if (!run) begin
			st_d    = port_protect_pkg::ST_IDLE; // see R2
			sh_d    = 8'h00;
			cnt_d   = 4'h0;
			ptr_d   = 8'h00;
			rd_d    = 1'b0;
			first_d = 1'b0;
			oe_d    = 1'b0;
			ctrl_d  = `PP_CTRL_RST;
			lock_d  = 1'b0;
			hold_d  = 10'h000;
		end
	end

	always_ff @(posedge mclk_in) begin
		st_q    <= st_d;
		sh_q    <= sh_d;
		cnt_q   <= cnt_d;
		ptr_q   <= ptr_d;
		rd_q    <= rd_d;
		first_q <= first_d;
		oe_q    <= oe_d;
		ctrl_q  <= ctrl_d;
		lock_q  <= lock_d;
		hold_q  <= hold_d;
		scl_p_q <= run & scl_s;
		sda_p_q <= run & sda_s;
		ocp_p_q <= run & boc_s;
	end

	// ****************************************
	// Mode decode and output drivers
	// ****************************************
	logic       cc_on_d, hi_ohm_d, clamp_d, db_d, sink_d, src_d;
	logic       bdis_d, adis_d, sw1_d, sw2_d, sense_d, act_d, flag_d;
	logic       is_off, is_hib, is_lowp, is_norm, any_fault;
	logic [1:0] sw_sel;

	assign is_off    = (mode_q == port_protect_pkg::MODE_OFF);
	assign is_hib    = (mode_q == port_protect_pkg::MODE_HIB);
	assign is_lowp   = (mode_q == port_protect_pkg::MODE_LOWP);
	assign is_norm   = (mode_q == port_protect_pkg::MODE_NORM);
	assign any_fault = ccov_s | otp_s | bov_s | aoc_s | lock_q;
	assign sw_sel    = ctrl_q[`PP_BIT_SW_HI:`PP_BIT_SW_LO];

	always_comb begin
		case (ctrl_q[`PP_BIT_MODE_HI:`PP_BIT_MODE_LO]) // see R12
			`PP_MODE_LOWP: mode_d = port_protect_pkg::MODE_LOWP;
			`PP_MODE_NORM: mode_d = port_protect_pkg::MODE_NORM;
			default:       mode_d = port_protect_pkg::MODE_HIB; // see R3
		endcase
		if (!run) begin
			mode_d = port_protect_pkg::MODE_OFF;
		end
		// CC stays off for the hold time after an overcurrent
		cc_on_d  = is_norm & ~(lock_q & ~hold_done);
		hi_ohm_d = is_lowp; // see R5
		clamp_d  = is_lowp; // see R6
		db_d     = is_off | is_hib; // see R5
		// Sink driver self-biased when off, cut on overcurrent
		if (is_off) begin
			sink_d = 1'b1; // see R8
		end else begin
			sink_d = ~ctrl_q[`PP_BIT_SINK_GATE] & ~lock_q; // see R13
		end
		src_d   = is_norm & ctrl_q[`PP_BIT_SOURCE_GATE] & ~lock_q; // see R8
		bdis_d  = is_norm & (ctrl_q[`PP_BIT_BUS_DIS] | lock_q); // see R13
		adis_d  = is_norm & (ctrl_q[`PP_BIT_AUX_DIS] | lock_q);
		sw1_d   = is_norm & ~lock_q & (sw_sel == `PP_SW_CONN1); // see R13
		sw2_d   = is_norm & ~lock_q & (sw_sel == `PP_SW_CONN2);
		sense_d = is_norm;
		act_d   = ~is_off;
		// Pin reports presence outside normal mode
		flag_d  = is_norm ? any_fault : vbus_s; // see R4 see R10
		ack_d   = lock_q ? (ctrl_q & `PP_ACK_OCP_KEEP) : ctrl_q; // see R9 see R11
		flags_d = {`PP_VARIANT, 1'b0, vbus_s, ccov_s, otp_s, bov_s, lock_q, aoc_s}; // see R9
		if (!run) begin
			ack_d   = 8'h00;
			flags_d = 8'h00;
		end
	end

	always_ff @(posedge mclk_in) begin
		mode_q             <= mode_d;
		ack_q              <= ack_d;
		flags_q            <= flags_d;
		sda_out            <= 1'b0;
		sda_oe_out         <= oe_d;
		fault_flag_out     <= 1'b0;
		fault_flag_oe_out  <= flag_d;
		cc_switch_on_out   <= cc_on_d;
		cc_high_ohmic_out  <= hi_ohm_d;
		cc_clamp_out       <= clamp_d;
		dead_batt_term_out <= db_d;
		sink_gate_on_out   <= sink_d;
		source_gate_on_out <= src_d;
		bus_discharge_out  <= bdis_d;
		aux_discharge_out  <= adis_d;
		conn_switch1_out   <= sw1_d;
		conn_switch2_out   <= sw2_d;
		current_sense_out  <= sense_d;
		i2c_active_out     <= act_d;
	end

endmodule

// ==== port_protect_monitor.sv ====
// ****
// Port-level checks
// ****
module port_protect_monitor (
	input wire logic mclk_in,            // clock
	input wire logic rst_n_in,           // sync reset
	input wire logic enable_in,          // enable pin
	input wire logic vbus_present_in,    // vbus seen
	input wire logic overtemp_in,        // overtemp
	input wire logic bus_overcurrent_in, // bus ocp
	input wire logic sda_oe_out,         // ack drive
	input wire logic fault_flag_oe_out,  // flag pin
	input wire logic cc_switch_on_out,   // cc on
	input wire logic cc_high_ohmic_out,  // cc high ohmic
	input wire logic cc_clamp_out,       // passive clamp
	input wire logic dead_batt_term_out, // dead batt
	input wire logic sink_gate_on_out,   // sink gate
	input wire logic source_gate_on_out, // source gate
	input wire logic bus_discharge_out,  // bus discharge
	input wire logic aux_discharge_out,  // aux discharge
	input wire logic conn_switch1_out,   // switch 1
	input wire logic conn_switch2_out,   // switch 2
	input wire logic i2c_active_out      // bus live
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!rst_n_in);
	property p_off;
		!enable_in [*6] |-> !i2c_active_out && !sda_oe_out && sink_gate_on_out
			&& dead_batt_term_out && !source_gate_on_out;
	endproperty
	a_off: assert property (p_off) else $error("off state wrong");
	property p_src;
		source_gate_on_out |-> cc_switch_on_out;
	endproperty
	a_src: assert property (p_src) else $error("source gate outside normal");
	property p_lowp;
		cc_high_ohmic_out |-> cc_clamp_out && !dead_batt_term_out && !cc_switch_on_out;
	endproperty
	a_lowp: assert property (p_lowp) else $error("low power pins wrong");
	property p_hib;
		dead_batt_term_out |-> !cc_switch_on_out && !cc_high_ohmic_out;
	endproperty
	a_hib: assert property (p_hib) else $error("cc on with dead batt");
	property p_sw;
		conn_switch1_out |-> !conn_switch2_out;
	endproperty
	a_sw: assert property (p_sw) else $error("both switches closed");
	property p_dis;
		bus_discharge_out || aux_discharge_out |-> !dead_batt_term_out && !cc_high_ohmic_out;
	endproperty
	a_dis: assert property (p_dis) else $error("discharge outside normal");
	property p_vbflag;
		($stable(vbus_present_in) && (dead_batt_term_out || cc_high_ohmic_out)) [*4]
			|-> fault_flag_oe_out == vbus_present_in;
	endproperty
	a_vbflag: assert property (p_vbflag) else $error("flag not vbus");
	property p_fault;
		(overtemp_in && cc_switch_on_out) [*4] |-> fault_flag_oe_out;
	endproperty
	a_fault: assert property (p_fault) else $error("fault not flagged");
	property p_ocp;
		$rose(bus_overcurrent_in) && cc_switch_on_out |-> ##[2:8] (!source_gate_on_out
			&& !sink_gate_on_out && !conn_switch1_out && !conn_switch2_out
			&& bus_discharge_out && aux_discharge_out && fault_flag_oe_out);
	endproperty
	a_ocp: assert property (p_ocp) else $error("overcurrent lock missing");
endmodule

// ==== bus_master_model.sv ====
// ****
// Controller side, about 400 kHz
// ****
module bus_master_model (
	input  wire logic mclk_in,   // clock
	input  wire logic sda_in,    // resolved data line
	output logic      scl_out,   // bus clock
	output logic      sda_oe_out // pull data low
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		scl_out = 1'b1;
		sda_oe_out = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge mclk_in);
		#1;
	endtask
	task automatic bit_io(input logic b, output logic r);
		sda_oe_out = !b;
		tick(21);
		scl_out = 1'b1;
		tick(21);
		r = sda_in;
		scl_out = 1'b0;
		tick(21);
	endtask
	task automatic xbyte(input logic [7:0] d, output logic [7:0] q, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r);
			q[i] = r;
		end
		bit_io(1'b1, ack);
	endtask
	// Data bits move only while the clock is low, so they never mimic start or stop
	task automatic xact(input logic [6:0] a, input logic [7:0] ptr, dat, input logic rd,
		output logic [7:0] q, output logic ok);
		logic k1, k2, k3, kx;
		logic [7:0] j;
		sda_oe_out = 1'b0;
		tick(16);
		scl_out = 1'b1;
		tick(16);
		sda_oe_out = 1'b1;
		tick(16);
		scl_out = 1'b0;
		tick(16);
		xbyte({a, 1'b0}, j, k1);
		xbyte(ptr, j, k2);
		q = 8'h00;
		if (rd) begin
			sda_oe_out = 1'b0;
			tick(16);
			scl_out = 1'b1;
			tick(16);
			sda_oe_out = 1'b1;
			tick(16);
			scl_out = 1'b0;
			tick(16);
			xbyte({a, 1'b1}, j, k3);
			xbyte(8'hff, q, kx);
		end else begin
			xbyte(dat, j, k3);
		end
		sda_oe_out = 1'b1;
		tick(16);
		scl_out = 1'b1;
		tick(16);
		sda_oe_out = 1'b0;
		tick(16);
		ok = !k1 && !k2 && !k3;
	endtask
endmodule

// ==== tb_top.sv ====
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk_in, rst_n_in, enable_in, addr_sel_in, scl_in, sda_in, m_oe;
	logic vbus_present_in, cc_overvolt_in, overtemp_in, bus_overvolt_in, bus_overcurrent_in;
	logic aux_overcurrent_in, sda_oe_out, fault_flag_out, fault_flag_oe_out, i2c_active_out;
	logic cc_switch_on_out, cc_high_ohmic_out, cc_clamp_out, dead_batt_term_out;
	logic sink_gate_on_out, source_gate_on_out, bus_discharge_out, aux_discharge_out;
	logic conn_switch1_out, conn_switch2_out, current_sense_out, ok, sda_out;
	logic [10:0] outs;
	logic [7:0] w, q;
	logic [6:0] a;
	int seed, bad_count, checked;
	assign sda_in = !(m_oe || sda_oe_out);
	assign outs = {cc_switch_on_out, cc_high_ohmic_out, cc_clamp_out, dead_batt_term_out,
		sink_gate_on_out, source_gate_on_out, bus_discharge_out, aux_discharge_out,
		conn_switch1_out, conn_switch2_out, current_sense_out};
	port_protect_mode_ctrl DUT (.mclk_in, .rst_n_in, .enable_in, .addr_sel_in, .scl_in,
		.sda_in, .vbus_present_in, .cc_overvolt_in, .overtemp_in, .bus_overvolt_in,
		.bus_overcurrent_in, .aux_overcurrent_in, .sda_out, .sda_oe_out, .fault_flag_out,
		.fault_flag_oe_out, .cc_switch_on_out, .cc_high_ohmic_out, .cc_clamp_out,
		.dead_batt_term_out, .sink_gate_on_out, .source_gate_on_out, .bus_discharge_out,
		.aux_discharge_out, .conn_switch1_out, .conn_switch2_out, .current_sense_out,
		.i2c_active_out);
	bus_master_model pm (.mclk_in, .sda_in, .scl_out(scl_in), .sda_oe_out(m_oe));
	initial begin
		mclk_in = 1'b0;
		forever #20 mclk_in = !mclk_in;
	end
	task automatic chk(input logic [15:0] s, e);
		checked++;
		if (s !== e) begin
			bad_count++;
			$display("unexpected at %0t: got %h want %h", $time, s, e);
		end
	endtask
	task automatic give_verdict;
		if (bad_count == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Mode 11 is never written, so it is not modelled here
	function automatic logic [10:0] exp_o(input logic [7:0] c);
		logic n, l;
		n = c[5:4] == 2'b01;
		l = c[5:4] == 2'b10;
		return {n, l, l, !n && !l, !c[3], n && c[2], n && c[6], n && c[7],
			n && c[1:0] == 2'b01, n && c[1:0] == 2'b10, n};
	endfunction
	initial begin
		#3600000;
		bad_count++;
		give_verdict();
	end
	initial begin
		seed = 73;
		{rst_n_in, enable_in, vbus_present_in, cc_overvolt_in, overtemp_in} = 5'h00;
		{bus_overvolt_in, bus_overcurrent_in, aux_overcurrent_in} = 3'h0;
		addr_sel_in = 1'($random(seed));
		a = {6'b011010, addr_sel_in};
		pm.tick(20);
		rst_n_in = 1'b1;
		pm.tick(10);
		pm.xact(a, 8'h00, 8'h15, 1'b0, q, ok);
		chk(ok, 1'b0);
		chk({i2c_active_out, outs}, {1'b0, exp_o(8'h00)});
		enable_in = 1'b1;
		pm.tick(10);
		chk({i2c_active_out, outs}, {1'b1, exp_o(8'h00)});
		pm.xact(a ^ 7'h01, 8'h00, 8'h15, 1'b0, q, ok);
		chk(ok, 1'b0);
		for (int i = 0; i < 6; i++) begin
			w = 8'($random(seed));
			w[5:4] = (i % 3 == 0) ? 2'b10 : (i % 3 == 1) ? 2'b00 : 2'b01;
			if (w[5:4] == 2'b01)
				bus_overcurrent_in = 1'b0;
			{vbus_present_in, cc_overvolt_in, overtemp_in, bus_overvolt_in,
				aux_overcurrent_in} = 5'($random(seed));
			pm.xact(a, 8'h00, w, 1'b0, q, ok);
			chk(ok, 1'b1);
			pm.tick(4);
			// Overcurrent outside normal mode must not lock
			if (w[5:4] != 2'b01)
				bus_overcurrent_in = 1'($random(seed));
			chk(outs, exp_o(w));
			chk(fault_flag_oe_out, (w[5:4] == 2'b01) ? cc_overvolt_in || overtemp_in
				|| bus_overvolt_in || aux_overcurrent_in : vbus_present_in);
			chk({sda_out, fault_flag_out}, 2'h0);
			pm.xact(a, 8'h01, 8'h00, 1'b1, q, ok);
			chk(q, w);
			pm.xact(a, 8'h02, 8'h00, 1'b1, q, ok);
			chk(q, {2'b00, vbus_present_in, cc_overvolt_in, overtemp_in, bus_overvolt_in,
				1'b0, aux_overcurrent_in});
		end
		pm.xact(a, 8'h00, 8'h00, 1'b1, q, ok);
		chk(q, 8'h00);
		{vbus_present_in, cc_overvolt_in, overtemp_in, bus_overvolt_in,
			aux_overcurrent_in} = 5'h10;
		pm.xact(a, 8'h00, 8'h95, 1'b0, q, ok);
		bus_overcurrent_in = 1'b1;
		pm.tick(12);
		chk(outs[10:1], 10'h00c);
		bus_overcurrent_in = 1'b0;
		pm.xact(a, 8'h00, 8'h15, 1'b0, q, ok);
		pm.xact(a, 8'h01, 8'h00, 1'b1, q, ok);
		chk(q, 8'h10);
		pm.xact(a, 8'h02, 8'h00, 1'b1, q, ok);
		chk({q, cc_switch_on_out, fault_flag_oe_out}, 10'h08b);
		pm.xact(a, 8'h00, 8'h18, 1'b0, q, ok);
		pm.tick(4);
		chk(outs, exp_o(8'h18));
		pm.xact(a, 8'h02, 8'h00, 1'b1, q, ok);
		chk(q, 8'h20);
		enable_in = 1'b0;
		pm.tick(8);
		enable_in = 1'b1;
		pm.tick(10);
		pm.xact(a, 8'h01, 8'h00, 1'b1, q, ok);
		chk(q, 8'h00);
		give_verdict();
	end
endmodule
bind port_protect_mode_ctrl port_protect_monitor mon (.mclk_in, .rst_n_in, .enable_in,
	.vbus_present_in, .overtemp_in, .bus_overcurrent_in, .sda_oe_out, .fault_flag_oe_out,
	.cc_switch_on_out, .cc_high_ohmic_out, .cc_clamp_out, .dead_batt_term_out,
	.sink_gate_on_out, .source_gate_on_out, .bus_discharge_out, .aux_discharge_out,
	.conn_switch1_out, .conn_switch2_out, .i2c_active_out);
